// ==== shared/psst_consts.svh ====
// Named constants for the program sequencer block.
// Assumes inclusion by bare name from the design files and the bench.
`ifndef PSST_CONSTS_SVH
`define PSST_CONSTS_SVH
// Counter and memory widths
`define PSST_PC_W        13
`define PSST_PC_MSB      12
`define PSST_MASK_SMALL  13'h0fff
`define PSST_MASK_LARGE  13'h1fff
`define PSST_LAST_PAGE   5'h1f
// Phases per instruction cycle
`define PSST_PHASE_FIRST 2'h0
`define PSST_PHASE_LAST  2'h3
// Vectors
`define PSST_RESET_VEC   13'h0000
`define PSST_IRQ_VEC     13'h0004
// Return stack
`define PSST_STK_DEPTH   4'h8
// Register byte offsets
`define PSST_OFF_PCL     8'h00
`define PSST_OFF_TBLO    8'h04
`define PSST_OFF_TBHI    8'h08
`define PSST_OFF_TBRES   8'h0c
`define PSST_OFF_STAT    8'h10
`define PSST_OFF_CFG     8'h14
// Reset values
`define PSST_CFG_RST     1'b1
`endif

// ==== shared/psst_pkg.sv ====
// Types shared by the program sequencer, its stack and its ALU.
// Assumes psst_consts.svh is on the include path.
package psst_pkg;
  // Sequencer states
  typedef enum logic [1:0] {S_DUMMY, S_EXEC, S_TABLE} psst_state_t;
  // Decoded instruction classes
  typedef enum logic [3:0] {
    OP_SEQ, OP_UNCONDITIONAL_BRANCH, OP_CALL, OP_SUBROUTINE_EXIT,
    OP_INTERRUPT_EXIT, OP_SKIP, OP_PAGE_TABLE_FETCH, OP_LAST_PAGE_TABLE_FETCH
  } psst_op_t;
  // ALU operations
  typedef enum logic [3:0] {
    ALU_PASS, ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_DAA, ALU_AND, ALU_OR,
    ALU_XOR, ALU_CPL, ALU_ROTR, ALU_ROTRC, ALU_ROTL, ALU_ROTLC, ALU_INC, ALU_DEC
  } psst_alu_t;
  // Skip conditions
  typedef enum logic [1:0] {SK_NONE, SK_ZERO, SK_NONZERO} psst_skip_t;
  // Status flags
  typedef struct packed {
    logic ov;
    logic z;
    logic ac;
    logic c;
  } psst_flags_t;
  // Decoder view of the instruction in execution
  typedef struct packed {
    psst_op_t   op;
    psst_alu_t  alu;
    psst_skip_t skip;
    logic       wr;
    logic       far;
    logic       to_acc;
    logic [7:0] dest;
    logic [7:0] opa;
    logic [7:0] opb;
    logic [12:0] target;
  } psst_dec_t;
  // Result write towards the data registers
  typedef struct packed {
    logic       en;
    logic       to_acc;
    logic       far;
    logic [7:0] addr;
    logic [7:0] data;
  } psst_wr_t;
endpackage

// ==== hw/psst_alu.sv ====
// Eight-bit ALU: arithmetic, logic, rotate, step and decimal adjust.
// Assumes operands and incoming flags are stable for the whole cycle.
`timescale 1ns/10ps
`include "psst_consts.svh"
module psst_alu
  import psst_pkg::*;
(
  input  wire psst_alu_t   op,
  input  wire logic [7:0]  a,
  input  wire logic [7:0]  b,
  input  wire psst_flags_t fin,
  output logic [7:0]       res,
  output psst_flags_t      fout
);
  logic [7:0] bb;     // Second adder operand
  logic       cin;    // Adder carry in
  logic [8:0] sum9;   // Full adder result
  logic [4:0] nib;    // Low nibble sum
  logic [7:0] adj;    // Decimal correction
  logic [8:0] dsum;   // Adjusted accumulator

  // Shared adder for add and subtract forms
  always_comb begin
    bb   = (op == ALU_SUB || op == ALU_SBC) ? ~b : b;
    cin  = (op == ALU_SUB) ? 1'b1 : ((op == ALU_ADC || op == ALU_SBC) ? fin.c : 1'b0);
    sum9 = {1'b0, a} + {1'b0, bb} + {8'h00, cin};
    nib  = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
    adj  = 8'h00;
    if (a[3:0] > 4'h9 || fin.ac) begin
      adj[3:0] = 4'h6;
    end
    if (a[7:4] > 4'h9 || fin.c) begin
      adj[7:4] = 4'h6;
    end
    dsum = {1'b0, a} + {1'b0, adj};
  end

  // Result and flag selection
  always_comb begin
    res  = a;
    fout = fin;
    case (op)
      ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC: begin
        res     = sum9[7:0];
        fout.c  = sum9[8];
        fout.ac = nib[4];
        fout.ov = (a[7] == bb[7]) && (sum9[7] != a[7]);
      end
      ALU_DAA: begin
        res    = dsum[7:0];
        fout.c = fin.c | dsum[8];
      end
      ALU_AND:   res = a & b;
      ALU_OR:    res = a | b;
      ALU_XOR:   res = a ^ b;
      ALU_CPL:   res = ~b;
      ALU_ROTR:  res = {b[0], b[7:1]};
      ALU_ROTL:  res = {b[6:0], b[7]};
      ALU_ROTRC: begin
        res    = {fin.c, b[7:1]};
        fout.c = b[0];
      end
      ALU_ROTLC: begin
        res    = {b[6:0], fin.c};
        fout.c = b[7];
      end
      ALU_INC:   res = b + 8'h01;
      ALU_DEC:   res = b - 8'h01;
      default:   res = b;
    endcase
    // Zero follows every result except rotates and pass
    if (op != ALU_PASS && op != ALU_ROTR && op != ALU_ROTL && op != ALU_ROTRC && op != ALU_ROTLC) begin
      fout.z = (res == 8'h00);
    end
  end
endmodule

// ==== hw/psst_stack.sv ====
// Eight-level return stack holding program counter values only.
// Assumes push and pop are never asked for in the same cycle.
`timescale 1ns/10ps
`include "psst_consts.svh"
module psst_stack
  import psst_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        push,
  input  wire logic        pop,
  input  wire logic [12:0] din,
  output logic [12:0]      dout,
  output logic             full,
  output logic [3:0]       level
);
  logic [12:0] mem_reg [0:7]; // Saved counter values
  logic [2:0]  ptr_reg;       // Next free slot, wraps
  logic [3:0]  cnt_reg;       // Filled levels

  // Entry storage, one writer per slot
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_slot
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mem_reg[gi] <= `PSST_RESET_VEC;
        end else if (push && ptr_reg == 3'(gi)) begin
          mem_reg[gi] <= din; // Full stack overwrites the oldest
        end
      end
    end
  endgenerate

  // Pointer and fill count; reset puts the pointer at slot 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_reg <= 3'h0;
      cnt_reg <= 4'h0;
    end else if (push) begin
      ptr_reg <= ptr_reg + 3'h1;
      if (cnt_reg != `PSST_STK_DEPTH) begin
        cnt_reg <= cnt_reg + 4'h1;
      end
    end else if (pop) begin
      ptr_reg <= ptr_reg - 3'h1;
      if (cnt_reg != 4'h0) begin
        cnt_reg <= cnt_reg - 4'h1;
      end
    end
  end

  assign dout  = mem_reg[ptr_reg - 3'h1];
  assign full  = (cnt_reg == `PSST_STK_DEPTH);
  assign level = cnt_reg;

  // Overflow keeps the stack full and moves on
  chk_ovf_keeps_full: assert property (@(posedge pclk) disable iff (!presetn)
    (push && full) |=> (full && ptr_reg == $past(ptr_reg) + 3'h1))
    else $error("overflow push lost fullness or pointer step");
endmodule

// ==== hw/psst_seq.sv ====
// Program sequencer: counter, fetch, return stack, table read, ALU issue.
// Assumes a same-clock program memory answering within one phase, a
// decoder that decodes instr_word combinationally into dec, and an APB master.
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/10ps
`include "psst_consts.svh"
module psst_seq
  import psst_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic [12:0]      pmem_addr,
  input  wire logic [15:0] pmem_data,
  output logic [15:0]      instr_word,
  output logic             instr_valid,
  input  wire psst_dec_t   dec,
  output psst_wr_t         wr,
  output psst_flags_t      status,
  input  wire logic        irq_req,
  output logic             irq_ack,
  output logic             irq_return,
  output logic [1:0]       phase
);
  psst_state_t state_reg;      // Sequencer state
  logic [1:0]  phase_reg;      // Phase within the cycle
  logic [12:0] pc_reg;         // Next address to fetch
  logic [12:0] fetch_addr_reg; // Address of prefetched word
  logic [12:0] pmem_addr_reg;  // Memory address driven
  logic [12:0] tab_addr_reg;   // Table word address
  logic [15:0] instr_reg;      // Prefetched instruction
  logic [7:0]  tblo_reg;       // Table pointer low
  logic [4:0]  tbhi_reg;       // Table pointer high
  logic [7:0]  tbres_reg;      // Table high result
  logic [7:0]  tab_dest_reg;   // Saved table destination
  logic        tab_far_reg;    // Saved far destination flag
  logic        cfg_large_reg;  // Large variant select
  logic        pcl_pend_reg;   // Low byte write waiting
  logic [7:0]  pcl_val_reg;    // Low byte to load
  logic        irq_pend_reg;   // Interrupt request recorded
  logic        boot_reg;       // First fetch after reset
  psst_wr_t    wr_reg;         // Result write pulse
  psst_flags_t status_reg;     // Status flags
  logic [31:0] prdata_reg;     // Read data
  logic [12:0] pc_mask;        // Width mask per variant
  logic [12:0] pc_inc;         // Sequential next address
  logic        cyc_end;        // Last phase of cycle
  logic        exec;           // Instruction in execution
  logic [7:0]  alu_res;        // ALU result
  psst_flags_t alu_f;          // ALU flags
  logic        skip_hit;       // Skip condition met
  logic        take_jump;      // Jump or call
  logic        take_ret;       // Either return
  logic        start_tab;      // Table fetch begins
  logic        redirect;       // Prefetch discarded
  logic        pcl_take;       // Low byte jump now
  logic        irq_take;       // Interrupt acknowledged
  logic        stk_push;       // Stack push
  logic        stk_pop;        // Stack pop
  logic [12:0] stk_dout;       // Top of stack
  logic        stk_full;       // Stack full
  logic [3:0]  stk_level;      // Stack fill
  logic        apb_wr;         // APB write access
  logic        apb_hit;        // Mapped address

  // Upper counter width per variant
  assign pc_mask = cfg_large_reg ? `PSST_MASK_LARGE : `PSST_MASK_SMALL;
  assign pc_inc  = (pc_reg + 13'h0001) & pc_mask;
  assign cyc_end = (phase_reg == `PSST_PHASE_LAST);
  assign exec    = (state_reg == S_EXEC);

  psst_alu u_alu (
    .op   (dec.alu),
    .a    (dec.opa),
    .b    (dec.opb),
    .fin  (status_reg),
    .res  (alu_res),
    .fout (alu_f)
  );

  // Decisions taken at the end of a cycle
  always_comb begin
    skip_hit  = exec && dec.op == OP_SKIP &&
                ((dec.skip == SK_ZERO && alu_res == 8'h00) ||
                 (dec.skip == SK_NONZERO && alu_res != 8'h00));
    take_jump = exec && (dec.op == OP_UNCONDITIONAL_BRANCH || dec.op == OP_CALL);
    take_ret  = exec && (dec.op == OP_SUBROUTINE_EXIT || dec.op == OP_INTERRUPT_EXIT);
    start_tab = exec && (dec.op == OP_PAGE_TABLE_FETCH || dec.op == OP_LAST_PAGE_TABLE_FETCH);
    redirect  = take_jump || take_ret || skip_hit;
    pcl_take  = cyc_end && pcl_pend_reg && state_reg != S_TABLE && !redirect && !start_tab;
    // Full stack withholds the acknowledge
    irq_take  = cyc_end && irq_pend_reg && !stk_full && exec && !redirect && !start_tab && !pcl_take;
    stk_push  = cyc_end && ((exec && dec.op == OP_CALL) || irq_take);
    stk_pop   = cyc_end && take_ret;
  end

  psst_stack u_stack (
    .pclk    (pclk),
    .presetn (presetn),
    .push    (stk_push),
    .pop     (stk_pop),
    .din     (fetch_addr_reg),
    .dout    (stk_dout),
    .full    (stk_full),
    .level   (stk_level)
  );

  // Four-phase instruction cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= `PSST_PHASE_FIRST;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  // Counter, fetch and memory address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_reg         <= `PSST_RESET_VEC;
      fetch_addr_reg <= `PSST_RESET_VEC;
      pmem_addr_reg  <= `PSST_RESET_VEC;
    end else if (phase_reg == `PSST_PHASE_FIRST) begin
      if (state_reg == S_TABLE) begin
        pmem_addr_reg <= tab_addr_reg; // Table word instead of fetch
      end else begin
        pmem_addr_reg  <= pc_reg; // Fetch in first phase
        fetch_addr_reg <= pc_reg;
        pc_reg         <= pc_inc;
      end
    end else if (cyc_end) begin
      if (take_jump) begin
        pc_reg <= dec.target & pc_mask;
      end else if (take_ret) begin
        pc_reg <= stk_dout & pc_mask;
      end else if (pcl_take) begin
        pc_reg <= {fetch_addr_reg[12:8], pcl_val_reg} & pc_mask;
      end else if (irq_take) begin
        pc_reg <= `PSST_IRQ_VEC & pc_mask;
      end
    end
  end

  // Sequencer state and prefetch latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= S_DUMMY;
      instr_reg <= 16'h0000;
    end else if (cyc_end) begin
      if (state_reg != S_TABLE) begin
        instr_reg <= pmem_data;
      end
      // Discarded prefetch becomes a dummy cycle
      if (redirect || pcl_take || irq_take) begin
        state_reg <= S_DUMMY;
      end else if (start_tab) begin
        state_reg <= S_TABLE; // Second cycle of table fetch
      end else begin
        state_reg <= S_EXEC;
      end
    end
  end

  // Table address and destination capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tab_addr_reg <= `PSST_RESET_VEC;
      tab_dest_reg <= 8'h00;
      tab_far_reg  <= 1'b0;
    end else if (cyc_end && start_tab) begin
      tab_dest_reg <= dec.dest;
      tab_far_reg  <= dec.far;
      if (dec.op == OP_LAST_PAGE_TABLE_FETCH) begin
        tab_addr_reg <= {`PSST_LAST_PAGE, tblo_reg} & pc_mask;
      end else begin
        tab_addr_reg <= ({fetch_addr_reg[12:8], 8'h00} + {tbhi_reg, tblo_reg}) & pc_mask;
      end
    end
  end

  // Table high result, hardware written only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tbres_reg <= 8'h00;
    end else if (cyc_end && state_reg == S_TABLE) begin
      tbres_reg <= pmem_data[15:8];
    end
  end

  // Result write pulse and status flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_reg     <= '0;
      status_reg <= '0;
    end else begin
      wr_reg <= '0;
      if (cyc_end && exec && (dec.op == OP_SEQ || dec.op == OP_SKIP)) begin
        status_reg <= alu_f;
        wr_reg     <= '{en: dec.wr, to_acc: dec.to_acc, far: dec.far, addr: dec.dest, data: alu_res};
      end else if (cyc_end && state_reg == S_TABLE) begin
        wr_reg <= '{en: 1'b1, to_acc: 1'b0, far: tab_far_reg, addr: tab_dest_reg, data: pmem_data[7:0]};
      end
    end
  end

  // Interrupt request record; a new request beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_pend_reg <= 1'b0;
    end else begin
      irq_pend_reg <= irq_req || (irq_pend_reg && !irq_take);
    end
  end

  // Reset marker for the first fetch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_reg <= 1'b1;
    end else if (phase_reg == `PSST_PHASE_FIRST) begin
      boot_reg <= 1'b0;
    end
  end

  // APB decode
  assign apb_wr  = psel && penable && pwrite;
  always_comb begin
    apb_hit = 1'b0;
    if (paddr == `PSST_OFF_PCL) begin
      apb_hit = 1'b1;
    end else if (paddr == `PSST_OFF_TBLO || paddr == `PSST_OFF_TBHI) begin
      apb_hit = 1'b1;
    end else if (paddr == `PSST_OFF_TBRES || paddr == `PSST_OFF_STAT) begin
      apb_hit = 1'b1;
    end else if (paddr == `PSST_OFF_CFG) begin
      apb_hit = 1'b1;
    end
  end

  // Software writes; a new low byte write wins over its clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tblo_reg      <= 8'h00;
      tbhi_reg      <= 5'h00;
      cfg_large_reg <= `PSST_CFG_RST;
      pcl_pend_reg  <= 1'b0;
      pcl_val_reg   <= 8'h00;
    end else begin
      pcl_pend_reg <= pcl_pend_reg && !pcl_take;
      if (apb_wr && paddr == `PSST_OFF_PCL) begin
        pcl_pend_reg <= 1'b1;
        pcl_val_reg  <= pwdata[7:0];
      end else if (apb_wr && paddr == `PSST_OFF_TBLO) begin
        tblo_reg <= pwdata[7:0];
      end else if (apb_wr && paddr == `PSST_OFF_TBHI) begin
        tbhi_reg <= pwdata[4:0];
      end else if (apb_wr && paddr == `PSST_OFF_CFG) begin
        cfg_large_reg <= pwdata[0];
      end
    end
  end

  // Read data captured in the setup phase; stack never readable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_reg <= 32'h0000_0000;
      if (paddr == `PSST_OFF_PCL) begin
        prdata_reg[7:0] <= fetch_addr_reg[7:0];
      end else if (paddr == `PSST_OFF_TBLO) begin
        prdata_reg[7:0] <= tblo_reg;
      end else if (paddr == `PSST_OFF_TBHI) begin
        prdata_reg[4:0] <= tbhi_reg;
      end else if (paddr == `PSST_OFF_TBRES) begin
        prdata_reg[7:0] <= tbres_reg;
      end else if (paddr == `PSST_OFF_STAT) begin
        prdata_reg[13:0] <= {stk_full, irq_pend_reg, pcl_pend_reg, state_reg, status_reg, stk_level, 1'b0};
      end else if (paddr == `PSST_OFF_CFG) begin
        prdata_reg[0] <= cfg_large_reg;
      end
    end
  end

  // Outputs
  assign prdata      = prdata_reg;
  assign pready      = 1'b1;
  assign pslverr     = psel && penable && !apb_hit;
  assign pmem_addr   = pmem_addr_reg;
  assign instr_word  = instr_reg;
  assign instr_valid = exec;
  assign wr          = wr_reg;
  assign status      = status_reg;
  assign irq_ack     = irq_take;
  assign irq_return  = cyc_end && exec && dec.op == OP_INTERRUPT_EXIT;
  assign phase       = phase_reg;

  // Checks
  // Sampled reset keeps the release edge out of the step check
  chk_seq_advance: assert property (@(posedge pclk) disable iff (!presetn)
    (presetn && phase_reg == `PSST_PHASE_FIRST && state_reg != S_TABLE)
      |=> pc_reg == (($past(pc_reg) + 13'h0001) & pc_mask))
    else $error("counter did not step by one");
  chk_branch_load: assert property (@(posedge pclk) disable iff (!presetn)
    (cyc_end && take_jump) |=> (pc_reg == ($past(dec.target) & pc_mask) && state_reg == S_DUMMY))
    else $error("branch target not loaded");
  chk_skip_dummy: assert property (@(posedge pclk) disable iff (!presetn)
    (cyc_end && skip_hit) |=> state_reg == S_DUMMY ##4 state_reg == S_EXEC)
    else $error("met skip did not insert one dummy");
  chk_pcl_page: assert property (@(posedge pclk) disable iff (!presetn)
    pcl_take |=> (pc_reg[12:8] == $past(fetch_addr_reg[12:8]) && pc_reg[7:0] == $past(pcl_val_reg)))
    else $error("low byte jump left page");
  chk_full_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_pend_reg && stk_full) |-> !irq_ack)
    else $error("acknowledge given on full stack");
  chk_reset_vec: assert property (@(posedge pclk) disable iff (!presetn)
    (boot_reg && phase_reg == `PSST_PHASE_FIRST) |=> pmem_addr_reg == `PSST_RESET_VEC)
    else $error("first fetch not at reset vector");
  chk_table_two: assert property (@(posedge pclk) disable iff (!presetn)
    (cyc_end && start_tab && !redirect) |=> (state_reg == S_TABLE) [*4] ##1 state_reg == S_EXEC)
    else $error("table fetch not two cycles");
  chk_table_write: assert property (@(posedge pclk) disable iff (!presetn)
    (cyc_end && state_reg == S_TABLE) |=> (wr_reg.en && wr_reg.data == $past(pmem_data[7:0])
      && tbres_reg == $past(pmem_data[15:8])))
    else $error("table bytes misrouted");
  chk_tbres_ro: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_wr && paddr == `PSST_OFF_TBRES && !(cyc_end && state_reg == S_TABLE)) |=> $stable(tbres_reg))
    else $error("software changed table high result");
  chk_phase_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    cyc_end |=> phase_reg == `PSST_PHASE_FIRST)
    else $error("instruction cycle not four phases");
  cov_call: cover property (@(posedge pclk) disable iff (!presetn) cyc_end && exec && dec.op == OP_CALL);
  cov_irq_ack: cover property (@(posedge pclk) disable iff (!presetn) irq_take);
  cov_table: cover property (@(posedge pclk) disable iff (!presetn) cyc_end && state_reg == S_TABLE);
  cov_overflow: cover property (@(posedge pclk) disable iff (!presetn) stk_push && stk_full);
endmodule

// ==== testbench/psst_prog_model.sv ====
// Program memory and decoder model seen by the sequencer.
// Assumes the bench loads the words and the sequencer reads on its clock.
`timescale 1ns/10ps
module psst_prog_model
  import psst_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic [12:0] pmem_addr,
  output logic [15:0]      pmem_data,
  input  wire logic [15:0] instr_word,
  output psst_dec_t        dec
);
  logic [15:0] mem [0:8191]; // Sixteen-bit program words
  // Word read by counter address
  assign pmem_data = mem[pmem_addr];
  // Decode: op in top bits, write flag, target below
  always_comb begin
    dec        = '0;
    dec.op     = psst_op_t'({1'b0, instr_word[15:13]});
    dec.alu    = ALU_ADD;
    dec.skip   = psst_skip_t'(instr_word[9:8]);
    dec.far    = instr_word[11];
    dec.wr     = instr_word[12];
    dec.dest   = instr_word[7:0];
    dec.target = {1'b0, instr_word[11:0]};
  end
endmodule

// ==== testbench/psst_seq_tb_top.sv ====
// Bench for the program sequencer: registers, branch, table, interrupt, jump.
// Assumes psst_pkg is compiled and the program model sits beside it.
`timescale 1ns/10ps
`include "psst_consts.svh"
module psst_seq_tb_top;
  import psst_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, irq_req, pready, pslverr, err, instr_valid, irq_ack, irq_return;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [12:0] pmem_addr;
  logic [15:0] pmem_data, instr_word;
  logic [1:0]  phase;
  psst_dec_t   dec;
  psst_wr_t    wr;
  psst_flags_t status;
  int          n_fail, checks, i;
  psst_seq dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pmem_addr(pmem_addr), .pmem_data(pmem_data), .instr_word(instr_word), .instr_valid(instr_valid),
    .dec(dec), .wr(wr), .status(status), .irq_req(irq_req), .irq_ack(irq_ack),
    .irq_return(irq_return), .phase(phase));
  psst_prog_model pm_u (.pclk(pclk), .pmem_addr(pmem_addr), .pmem_data(pmem_data),
    .instr_word(instr_word), .dec(dec));
  // Free running clock
  always #2 pclk = ~pclk;
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // Bounded wait for a fetch address
  task automatic wait_addr(input logic [12:0] a);
    for (i = 0; i < 300 && pmem_addr !== a; i++) @(posedge pclk) #1;
    chk(pmem_addr, a);
  endtask
  task automatic give_verdict;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Table pointers, config reset value, unmapped access
  task automatic t_regs;
    apb(1, `PSST_OFF_TBLO, 32'h20); apb(1, `PSST_OFF_TBHI, 32'h0);
    apb(0, `PSST_OFF_CFG, 32'h0); chk(rd, 32'h1);
    apb(0, 8'h18, 32'h0); chk(err, 32'h1); chk(rd, 32'h0);
    $display("test regs done");
  endtask
  // Branch, sequential step, table read, read-only result
  task automatic t_table;
    wait_addr(13'h100);
    repeat (4) @(posedge pclk) #1;
    chk(pmem_addr, 13'h101);
    for (i = 0; i < 100 && wr.en !== 1'b1; i++) @(posedge pclk) #1;
    chk(wr.data, 8'h5c);
    chk(wr.addr, 32'h33);
    chk(wr.far, 32'h1);
    chk(status, 32'h4);
    apb(0, `PSST_OFF_TBRES, 32'h0); chk(rd, 32'h12);
    apb(1, `PSST_OFF_TBRES, 32'hff); apb(0, `PSST_OFF_TBRES, 32'h0); chk(rd, 32'h12);
    $display("test table done");
  endtask
  // Interrupt entry and exit back to the loop
  task automatic t_irq;
    @(posedge pclk) irq_req <= 1'b1;
    @(posedge pclk) irq_req <= 1'b0;
    for (i = 0; i < 300 && irq_ack !== 1'b1; i++) @(posedge pclk) #1;
    chk(irq_ack, 32'h1);
    chk(phase, 32'h3);
    chk(instr_valid, 32'h1);
    wait_addr(`PSST_IRQ_VEC);
    for (i = 0; i < 300 && irq_return !== 1'b1; i++) @(posedge pclk) #1;
    chk(irq_return, 32'h1);
    wait_addr(13'h108);
    apb(0, `PSST_OFF_STAT, 32'h0); chk(rd[4:1], 32'h0);
    $display("test irq done");
  endtask
  // Low byte write jumps within the page
  task automatic t_pcl;
    apb(0, `PSST_OFF_PCL, 32'h0); chk(rd[31:8], 32'h0);
    apb(1, `PSST_OFF_PCL, 32'h30);
    wait_addr(13'h130);
    $display("test pcl done");
  endtask
  // Call, met skip over a branch, return through the stack
  task automatic t_call;
    wait_addr(13'h140);
    apb(0, `PSST_OFF_STAT, 32'h0); chk(rd[4:1], 32'h1);
    wait_addr(13'h131);
    apb(0, `PSST_OFF_STAT, 32'h0); chk(rd[4:1], 32'h0);
    $display("test call done");
  endtask
  // Recursion fills the stack; interrupt waits for a return
  task automatic t_full;
    repeat (120) @(posedge pclk);
    apb(0, `PSST_OFF_STAT, 32'h0); chk(rd[13], 32'h1);
    chk(rd[4:1], 32'h8);
    @(posedge pclk) irq_req <= 1'b1;
    @(posedge pclk) irq_req <= 1'b0;
    repeat (40) @(posedge pclk);
    apb(0, `PSST_OFF_STAT, 32'h0); chk(rd[12], 32'h1);
    pm_u.mem[13'h151] <= 16'h6000;
    for (i = 0; i < 300 && irq_ack !== 1'b1; i++) @(posedge pclk) #1;
    chk(irq_ack, 32'h1);
    $display("test full done");
  endtask
  // Program image, reset, tests
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; irq_req = 0;
    n_fail = 0; checks = 0;
    for (i = 0; i < 8192; i++) pm_u.mem[i] = 16'h0000;
    pm_u.mem[3] = 16'h2100; pm_u.mem[4] = 16'h8000; pm_u.mem[13'h105] = 16'hd833;
    pm_u.mem[13'h108] = 16'h2107; pm_u.mem[13'h120] = 16'h125c;
    pm_u.mem[13'h130] = 16'h4140; pm_u.mem[13'h131] = 16'h4150; pm_u.mem[13'h140] = 16'ha100;
    pm_u.mem[13'h141] = 16'h2000; pm_u.mem[13'h142] = 16'h6000; pm_u.mem[13'h151] = 16'h4150;
    repeat (16) @(posedge pclk);
    chk(pmem_addr, `PSST_RESET_VEC);
    presetn <= 1'b1;
    t_regs; t_table; t_irq; t_pcl; t_call; t_full;
    give_verdict;
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    give_verdict;
  end
endmodule
